//--- shared/mfs_pkg.sv
`default_nettype none
package mfs_pkg;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CFG    = 8'h04;
  localparam logic [7:0] OFS_AUX    = 8'h08;
  localparam logic [7:0] OFS_NET    = 8'h0C;
  localparam logic [7:0] OFS_RAMP   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_COUNT  = 8'h18;
  localparam int CTRL_PTC_EN = 0;
  localparam int CTRL_PHR_EN = 1;
  localparam int CTRL_PUMP   = 2;
  localparam int CTRL_CLEAR  = 3;
  localparam int CTRL_START  = 4;
  localparam int CTRL_STOP   = 5;
  localparam logic [3:0] RETRY_DEFAULT  = 4'h3;
  localparam logic [6:0] STARTS_MAX_LIM = 7'd99;
  localparam logic [6:0] STARTS_DEFAULT = 7'd2;
  localparam logic [7:0] START_RAMP_MAX = 8'd30;
  localparam logic [7:0] STOP_RAMP_MAX  = 8'd120;
  localparam logic [7:0] CAP_TRIP_PCT   = 8'd100;
  localparam longint CLK_HZ        = 200_000_000;
  localparam longint SAVE_HOURS    = 12;
  localparam longint SEC_PER_HOUR  = 3600;
  localparam longint SEC_CYC       = CLK_HZ;
  localparam longint HOUR_CYC      = SEC_PER_HOUR * CLK_HZ;
  localparam longint SAVE_CYC      = SAVE_HOURS * HOUR_CYC;
  // aux1 at-speed, aux2 fault, aux3 alarm, aux4 run command, all open
  localparam logic [15:0] AUX_RESET = 16'h0231;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PRE = 3'b001, ST_START = 3'b011,
    ST_RUN = 3'b010, ST_STOP = 3'b110, ST_FAULT = 3'b111
  } mfs_state_e;
  typedef enum logic [3:0] {
    FLT_NONE = 4'h0, FLT_PTC = 4'h1, FLT_OPEN_GATE = 4'h2,
    FLT_LINE_PRE = 4'h3, FLT_LINE_RUN = 4'h4, FLT_PHASE_REV = 4'h5,
    FLT_STARTS = 4'h6, FLT_POLE_OT = 4'h7, FLT_OVERLOAD = 4'h8
  } mfs_fault_e;
  typedef enum logic [2:0] {
    AUX_NORMAL = 3'h0, AUX_AT_SPEED = 3'h1, AUX_ALARM = 3'h2,
    AUX_FAULT = 3'h3, AUX_NETWORK = 3'h4, AUX_EXT_BYPASS = 3'h5
  } mfs_aux_e;
  typedef struct packed {
    logic [2:0] gate_fired;
    logic [2:0] leg_collapsed;
  } mfs_pole_s;
  typedef struct packed {
    logic [2:0] line_loss;
    logic [2:0] load_missing;
    logic [2:0] scr_shorted;
  } mfs_line_s;
endpackage
`default_nettype wire

//--- hdl/mfs_supervisor.sv
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mfs_supervisor #(
  parameter longint SEC_CYCLES  = mfs_pkg::SEC_CYC,
  parameter longint HOUR_CYCLES = mfs_pkg::HOUR_CYC,
  parameter longint SAVE_CYCLES = mfs_pkg::SAVE_CYC
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // power stage and line feedback
  input  wire mfs_pkg::mfs_pole_s pole_fb,
  input  wire mfs_pkg::mfs_line_s line_fb,
  input  wire logic              temp_ok,
  input  wire logic              phase_reversed,
  input  wire logic              at_speed_in,
  input  wire logic              braking,
  input  wire logic [7:0]        thermal_cap_pct,
  input  wire logic              alarm_in,
  input  wire logic              winding_thermistor_over,
  input  wire logic              winding_thermistor_short,
  input  wire logic [1:0]        option_in,
  // outputs
  output logic [3:0]             aux_out,
  output logic                   gate_enable,
  output logic                   fault_active,
  output logic                   nv_save,
  output logic                   volt_meter_valid
);
  import mfs_pkg::*;

  mfs_state_e  state_reg;
  mfs_state_e  state_next;
  mfs_fault_e  fault_reg;
  mfs_fault_e  trip_next;
  logic [1:0]  phase_reg;
  logic [1:0]  phase_next;
  logic [2:0]  ctrl_reg;
  logic        clear_reg;
  logic        start_reg;
  logic        stop_reg;
  logic [3:0]  retry_lim_reg;
  logic [6:0]  starts_max_reg;
  logic [15:0] aux_cfg_reg;
  logic [3:0]  net_reg;
  logic [7:0]  ramp_up_reg;
  logic [7:0]  ramp_dn_reg;
  logic [3:0]  retry_reg;
  logic [6:0]  starts_reg;
  logic [39:0] hour_cnt_reg;
  logic [47:0] save_cnt_reg;
  logic [31:0] sec_cnt_reg;
  logic [7:0]  stop_sec_reg;
  logic [2:0]  fired_reg;
  logic        run_cmd_reg;
  logic        og_hit;
  logic        clr_ok;
  logic        wr_en;
  logic        setup;
  logic [31:0] rd_next;
  logic        bad_next;

  function automatic logic [1:0] first_phase(input logic [2:0] v);
    first_phase = v[0] ? 2'd1 : v[1] ? 2'd2 : v[2] ? 2'd3 : 2'd0;
  endfunction

  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lim);
    clamp8 = (v > lim) ? lim : v;
  endfunction

  // aux 1 may only be at-speed or external bypass; bypass is never nc
  function automatic logic [3:0] aux_fix(input logic [3:0] v,
                                         input int idx);
    logic [3:0] r;
    r = v;
    if (idx == 0 && v[2:0] != AUX_AT_SPEED && v[2:0] != AUX_EXT_BYPASS)
      r = {v[3], AUX_AT_SPEED};
    if (idx == 3)
      r = {1'b0, AUX_NORMAL};
    if (r[2:0] == AUX_EXT_BYPASS)
      r[3] = 1'b0;
    aux_fix = r;
  endfunction

  // apb: no wait states, read data and error come from flops loaded in the setup cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    rd_next = 32'h0000_0000;
    bad_next = 1'b0;
    unique case (paddr)
      OFS_CTRL:   rd_next = {29'h0, ctrl_reg};
      OFS_CFG:    rd_next = {17'h0, starts_max_reg, 4'h0, retry_lim_reg};
      OFS_AUX:    rd_next = {16'h0, aux_cfg_reg};
      OFS_NET:    rd_next = {28'h0, net_reg};
      OFS_RAMP:   rd_next = {8'h0, ramp_dn_reg, 8'h0, ramp_up_reg};
      OFS_STATUS: rd_next = {14'h0, option_in, aux_out,
                             volt_meter_valid, run_cmd_reg, phase_reg,
                             fault_reg, 1'b0, state_reg};
      OFS_COUNT:  rd_next = {13'h0, starts_reg, 8'h0, retry_reg};
      default:    bad_next = 1'b1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rd_next : 32'h0000_0000;
      pslverr <= setup && bad_next;
    end
  end

  // configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= 3'h1;
      retry_lim_reg <= RETRY_DEFAULT;
      starts_max_reg <= STARTS_DEFAULT;
      aux_cfg_reg <= AUX_RESET;
      net_reg <= 4'h0;
      ramp_up_reg <= 8'h0A;
      ramp_dn_reg <= 8'h0A;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: ctrl_reg <= pwdata[2:0];
        OFS_CFG: begin
          retry_lim_reg <= pwdata[3:0];
          starts_max_reg <= (pwdata[14:8] > STARTS_MAX_LIM) ?
                            STARTS_MAX_LIM : pwdata[14:8];
        end
        OFS_AUX: begin
          for (int i = 0; i < 4; i++)
            aux_cfg_reg[i*4 +: 4] <= aux_fix(pwdata[i*4 +: 4], i);
        end
        OFS_NET: net_reg <= pwdata[3:0];
        OFS_RAMP: begin
          // pump limits; outside pump mode the full byte is kept
          ramp_up_reg <= ctrl_reg[CTRL_PUMP] ?
                         clamp8(pwdata[7:0], START_RAMP_MAX) :
                         pwdata[7:0];
          ramp_dn_reg <= ctrl_reg[CTRL_PUMP] ?
                         clamp8(pwdata[23:16], STOP_RAMP_MAX) :
                         pwdata[23:16];
        end
        default: ;
      endcase
    end
  end

  // command strobes, one cycle each
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clear_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      clear_reg <= wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLEAR];
      start_reg <= wr_en && paddr == OFS_CTRL && pwdata[CTRL_START];
      stop_reg <= wr_en && paddr == OFS_CTRL && pwdata[CTRL_STOP];
    end
  end

  // gate pulse seen last cycle, leg must have collapsed by now
  always_ff @(posedge mclk) begin
    if (!rst_n)
      fired_reg <= 3'h0;
    else
      fired_reg <= pole_fb.gate_fired;
  end
  assign og_hit = (state_reg == ST_START || state_reg == ST_STOP) &&
                  |(fired_reg & ~pole_fb.leg_collapsed);
  assign clr_ok = clear_reg &&
                  (fault_reg != FLT_POLE_OT || temp_ok);

  // trip evaluation; first match wins, thermistor only when alone
  always_comb begin
    trip_next = FLT_NONE;
    phase_next = 2'd0;
    if (thermal_cap_pct >= CAP_TRIP_PCT)
      trip_next = FLT_OVERLOAD;
    else if ((state_reg == ST_START || state_reg == ST_STOP) && !temp_ok)
      trip_next = FLT_POLE_OT;
    else if (og_hit && retry_reg >= retry_lim_reg)
      trip_next = FLT_OPEN_GATE;
    else if (state_reg == ST_PRE &&
             |(line_fb.line_loss | line_fb.load_missing |
               line_fb.scr_shorted)) begin
      trip_next = FLT_LINE_PRE;
      phase_next = first_phase(line_fb.line_loss | line_fb.load_missing |
                               line_fb.scr_shorted);
    end else if (state_reg == ST_RUN &&
                 |(line_fb.line_loss | line_fb.load_missing))
      trip_next = FLT_LINE_RUN;
    else if (state_reg == ST_PRE && ctrl_reg[CTRL_PHR_EN] &&
             phase_reversed)
      trip_next = FLT_PHASE_REV;
    else if (state_reg == ST_IDLE && start_reg &&
             starts_reg >= starts_max_reg)
      trip_next = FLT_STARTS;
    else if (ctrl_reg[CTRL_PTC_EN] && fault_reg == FLT_NONE &&
             (winding_thermistor_over || winding_thermistor_short))
      trip_next = FLT_PTC;
  end

  // fault latch; a new trip in the clear cycle keeps the old fault latched
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_reg <= FLT_NONE;
      phase_reg <= 2'd0;
    end else if (fault_reg == FLT_NONE && trip_next != FLT_NONE) begin
      fault_reg <= trip_next;
      phase_reg <= phase_next;
    end else if (clr_ok && trip_next == FLT_NONE) begin
      fault_reg <= FLT_NONE;
      phase_reg <= 2'd0;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (start_reg && starts_reg < starts_max_reg)
                  state_next = ST_PRE;
      ST_PRE:   state_next = ST_START;
      ST_START: if (og_hit)
                  state_next = ST_PRE;
                else if (stop_reg)
                  state_next = ST_STOP;
                else if (at_speed_in)
                  state_next = ST_RUN;
      ST_RUN:   if (stop_reg)
                  state_next = ST_STOP;
      ST_STOP:  if (stop_sec_reg >= ramp_dn_reg)
                  state_next = ST_IDLE;
      ST_FAULT: if (clr_ok && trip_next == FLT_NONE)
                  state_next = ST_IDLE;
      default:  state_next = ST_FAULT;
    endcase
    if (trip_next != FLT_NONE || fault_reg != FLT_NONE) begin
      if (!(state_reg == ST_FAULT && clr_ok && trip_next == FLT_NONE))
        state_next = ST_FAULT;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // restart attempts, cleared once the motor runs or on clear
  always_ff @(posedge mclk) begin
    if (!rst_n)
      retry_reg <= 4'h0;
    else if (state_reg == ST_RUN || clr_ok)
      retry_reg <= 4'h0;
    else if (og_hit && retry_reg < retry_lim_reg)
      retry_reg <= retry_reg + 4'h1;
  end

  // starts counted inside a fixed hour window
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hour_cnt_reg <= 40'h0;
      starts_reg <= 7'h0;
    end else if (hour_cnt_reg >= 40'(HOUR_CYCLES - 1)) begin
      hour_cnt_reg <= 40'h0;
      starts_reg <= 7'h0;
    end else begin
      hour_cnt_reg <= hour_cnt_reg + 40'h1;
      if (state_reg == ST_IDLE && state_next == ST_PRE &&
          starts_reg < STARTS_MAX_LIM)
        starts_reg <= starts_reg + 7'h1;
    end
  end

  // stop ramp timing in whole seconds
  always_ff @(posedge mclk) begin
    if (!rst_n || state_reg != ST_STOP) begin
      sec_cnt_reg <= 32'h0;
      stop_sec_reg <= 8'h0;
    end else if (sec_cnt_reg >= 32'(SEC_CYCLES - 1)) begin
      sec_cnt_reg <= 32'h0;
      stop_sec_reg <= stop_sec_reg + 8'h1;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h1;
    end
  end

  // periodic save strobe for elapsed time
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      save_cnt_reg <= 48'h0;
      nv_save <= 1'b0;
    end else if (save_cnt_reg >= 48'(SAVE_CYCLES - 1)) begin
      save_cnt_reg <= 48'h0;
      nv_save <= 1'b1;
    end else begin
      save_cnt_reg <= save_cnt_reg + 48'h1;
      nv_save <= 1'b0;
    end
  end

  // run command level for the normal function
  always_ff @(posedge mclk) begin
    if (!rst_n)
      run_cmd_reg <= 1'b0;
    else if (stop_reg || state_next == ST_FAULT)
      run_cmd_reg <= 1'b0;
    else if (start_reg && state_next == ST_PRE)
      run_cmd_reg <= 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aux_out <= 4'h0;
      gate_enable <= 1'b0;
      fault_active <= 1'b0;
      volt_meter_valid <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        logic lvl;
        lvl = 1'b0;
        unique case (aux_cfg_reg[i*4 +: 3])
          AUX_NORMAL:     lvl = run_cmd_reg;
          AUX_AT_SPEED:   lvl = state_reg == ST_RUN;
          AUX_ALARM:      lvl = alarm_in;
          AUX_FAULT:      lvl = fault_reg != FLT_NONE;
          AUX_NETWORK:    lvl = net_reg[i];
          AUX_EXT_BYPASS: lvl = state_reg == ST_RUN;
          default:        lvl = 1'b0;
        endcase
        aux_out[i] <= lvl ^ aux_cfg_reg[i*4 + 3];
      end
      gate_enable <= (state_reg == ST_START || state_reg == ST_RUN ||
                      state_reg == ST_STOP) && fault_reg == FLT_NONE;
      fault_active <= fault_reg != FLT_NONE;
      volt_meter_valid <= !braking;
    end
  end

  a_og_gate_only: assert property (@(posedge mclk) disable iff (!rst_n)
    (retry_reg != 4'h0 && retry_reg != $past(retry_reg)) |->
      $past(state_reg == ST_START || state_reg == ST_STOP))
    else $error("open gate counted outside ramping");
  a_ptc_alone: assert property (@(posedge mclk) disable iff (!rst_n)
    (fault_reg == FLT_PTC && $past(fault_reg) != FLT_PTC) |->
      $past(fault_reg) == FLT_NONE)
    else $error("thermistor trip over another fault");
  a_ptc_needs_en: assert property (@(posedge mclk) disable iff (!rst_n)
    (trip_next == FLT_PTC) |-> ctrl_reg[CTRL_PTC_EN] &&
      (winding_thermistor_over || winding_thermistor_short))
    else $error("thermistor trip without cause");
  a_retry_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    retry_reg <= retry_lim_reg || $past(wr_en))
    else $error("restart attempts over limit");
  a_run_no_phase: assert property (@(posedge mclk) disable iff (!rst_n)
    (fault_reg == FLT_LINE_RUN) |-> phase_reg == 2'd0)
    else $error("running line fault carries a phase");
  a_pre_phase: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(fault_reg == FLT_LINE_PRE) |-> phase_reg != 2'd0)
    else $error("pre-start line fault without phase");
  a_starts_cap: assert property (@(posedge mclk) disable iff (!rst_n)
    starts_reg <= STARTS_MAX_LIM)
    else $error("start count above ceiling");
  a_ot_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(fault_reg) == FLT_POLE_OT && fault_reg == FLT_NONE) |->
      $past(temp_ok))
    else $error("overtemp cleared while hot");
  a_overload: assert property (@(posedge mclk) disable iff (!rst_n)
    (thermal_cap_pct >= CAP_TRIP_PCT) |=> fault_reg != FLT_NONE)
    else $error("overload not latched");
  a_fault_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    (fault_reg != FLT_NONE) |=> !gate_enable && fault_active)
    else $error("gating during fault");
  a_meter_brake: assert property (@(posedge mclk) disable iff (!rst_n)
    braking |=> !volt_meter_valid)
    else $error("voltage metering valid while braking");
  a_aux4_run: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 aux_out[3] == $past(run_cmd_reg))
    else $error("aux four not following run command");
endmodule
`default_nettype wire

//--- dv/mfs_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module mfs_stage_model (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // gating command and injected open legs
  input  wire logic               gate_enable,
  input  wire logic [2:0]         open_leg,
  // leg feedback
  output var  mfs_pkg::mfs_pole_s pole_fb
);
  import mfs_pkg::*;
  logic [1:0] cnt_reg;
  logic [2:0] fired_reg;
  logic [2:0] coll_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  // all legs fire every fourth cycle, only while gating is allowed
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fired_reg <= 3'h0;
    end else begin
      fired_reg <= {3{gate_enable && cnt_reg == 2'h0}};
    end
  end
  // an open leg keeps its voltage, so its collapse never comes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      coll_reg <= 3'h0;
    end else begin
      coll_reg <= fired_reg & ~open_leg;
    end
  end
  assign pole_fb = '{gate_fired: fired_reg, leg_collapsed: coll_reg};
endmodule
`default_nettype wire

//--- dv/motor_fault_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module motor_fault_supervisor_bench;
  import mfs_pkg::*;
  typedef struct packed {
    logic [15:0] cfg;
    logic [3:0]  net;
    logic        alarm;
    logic [3:0]  exp;
  } mfs_row_s;
  localparam mfs_row_s ROWS [6] = '{
    '{16'h0230, 4'h0, 1'b0, 4'h0}, '{16'h0230, 4'h0, 1'b1, 4'h4},
    '{16'h0B20, 4'h0, 1'b0, 4'h4}, '{16'h0C40, 4'h2, 1'b0, 4'h6},
    '{16'hBC4D, 4'hE, 1'b0, 4'h2}, '{16'h0C43, 4'h4, 1'b0, 4'h0}};
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready, pslverr, err;
  logic [31:0] prdata, rdv;
  mfs_pole_s   pole_fb;
  mfs_line_s   line_fb = '0;
  logic        temp_ok = 1'b1;
  logic        phase_rev = 1'b0;
  logic        at_speed = 1'b0;
  logic        braking = 1'b0;
  logic [7:0]  cap = 8'h00;
  logic        alarm_in = 1'b0;
  logic        th_over = 1'b0;
  logic        th_short = 1'b0;
  logic [1:0]  option_in = 2'h0;
  logic [2:0]  open_leg = 3'h0;
  logic [3:0]  aux_out;
  logic        gate_enable, fault_active, nv_save, volt_meter_valid;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          pulses;
  mfs_supervisor #(.SEC_CYCLES(10), .HOUR_CYCLES(200), .SAVE_CYCLES(50)) dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pole_fb(pole_fb),
    .line_fb(line_fb), .temp_ok(temp_ok), .phase_reversed(phase_rev),
    .at_speed_in(at_speed), .braking(braking), .thermal_cap_pct(cap),
    .alarm_in(alarm_in), .winding_thermistor_over(th_over),
    .winding_thermistor_short(th_short), .option_in(option_in),
    .aux_out(aux_out), .gate_enable(gate_enable),
    .fault_active(fault_active), .nv_save(nv_save),
    .volt_meter_valid(volt_meter_valid));
  mfs_stage_model stage (.mclk(mclk), .rst_n(rst_n),
    .gate_enable(gate_enable), .open_leg(open_leg), .pole_fb(pole_fb));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // a leading edge keeps two transfers from driving psel in one step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, OFS_CTRL, d);
    repeat (2) @(posedge mclk);
  endtask
  task automatic st(input logic [2:0] s, input logic [3:0] f);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(32'({rdv[7:4], rdv[2:0]}), 32'({f, s}));
  endtask
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      n++;
    end while (rdv[2:0] !== s && n < 200);
    if (n >= 200) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(rdv, 32'h0000_0001);
    apb(1'b0, OFS_CFG, 32'h0000_0000);
    chk(rdv, 32'h0000_0203);
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, OFS_CFG, 32'h0000_7F03);
    apb(1'b0, OFS_CFG, 32'h0000_0000);
    chk(rdv, 32'h0000_6303);
    option_in <= 2'h2;
    braking <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(volt_meter_valid), 32'h0000_0000);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(32'(rdv[17:16]), 32'h0000_0002);
    braking <= 1'b0;
    pulses = 0;
    repeat (200) begin
      @(posedge mclk);
      if (nv_save === 1'b1) pulses++;
    end
    chk(32'(pulses), 32'h0000_0004);
    chk(32'(volt_meter_valid), 32'h0000_0001);
    foreach (ROWS[i]) begin
      apb(1'b1, OFS_AUX, 32'(ROWS[i].cfg));
      apb(1'b1, OFS_NET, 32'(ROWS[i].net));
      alarm_in <= ROWS[i].alarm;
      repeat (3) @(posedge mclk);
      chk(32'(aux_out), 32'(ROWS[i].exp));
    end
    ctl(32'h0000_0005);
    apb(1'b1, OFS_RAMP, 32'h00FF_00FF);
    apb(1'b0, OFS_RAMP, 32'h0000_0000);
    chk(rdv, 32'h0078_001E);
    apb(1'b1, OFS_RAMP, 32'h0005_0003);
    apb(1'b1, OFS_AUX, 32'h0000_0230);
    ctl(32'h0000_0000);
    th_over <= 1'b1;
    repeat (3) @(posedge mclk);
    st(ST_IDLE, FLT_NONE);
    ctl(32'h0000_0001);
    st(ST_FAULT, FLT_PTC);
    chk(32'(fault_active), 32'h0000_0001);
    th_over <= 1'b0;
    ctl(32'h0000_0009);
    st(ST_IDLE, FLT_NONE);
    line_fb.scr_shorted <= 3'h2;
    ctl(32'h0000_0011);
    wait_st(ST_FAULT);
    st(ST_FAULT, FLT_LINE_PRE);
    chk(32'(rdv[9:8]), 32'h0000_0002);
    th_short <= 1'b1;
    repeat (3) @(posedge mclk);
    st(ST_FAULT, FLT_LINE_PRE);
    th_short <= 1'b0;
    line_fb.scr_shorted <= 3'h0;
    ctl(32'h0000_0009);
    phase_rev <= 1'b1;
    ctl(32'h0000_0013);
    wait_st(ST_FAULT);
    st(ST_FAULT, FLT_PHASE_REV);
    ctl(32'h0000_0009);
    ctl(32'h0000_0011);
    wait_st(ST_START);
    st(ST_START, FLT_NONE);
    at_speed <= 1'b1;
    wait_st(ST_RUN);
    chk(32'(aux_out), 32'h0000_0009);
    open_leg <= 3'h1;
    repeat (40) @(posedge mclk);
    st(ST_RUN, FLT_NONE);
    open_leg <= 3'h0;
    cap <= 8'h63;
    repeat (3) @(posedge mclk);
    st(ST_RUN, FLT_NONE);
    cap <= 8'h64;
    wait_st(ST_FAULT);
    st(ST_FAULT, FLT_OVERLOAD);
    chk(32'({gate_enable, aux_out[1]}), 32'h0000_0001);
    cap <= 8'h00;
    phase_rev <= 1'b0;
    ctl(32'h0000_0009);
    ctl(32'h0000_0011);
    wait_st(ST_RUN);
    ctl(32'h0000_0021);
    st(ST_STOP, FLT_NONE);
    chk(32'(aux_out[3]), 32'h0000_0000);
    wait_st(ST_IDLE);
    ctl(32'h0000_0011);
    wait_st(ST_RUN);
    line_fb.line_loss <= 3'h4;
    wait_st(ST_FAULT);
    st(ST_FAULT, FLT_LINE_RUN);
    chk(32'(rdv[9:8]), 32'h0000_0000);
    line_fb.line_loss <= 3'h0;
    at_speed <= 1'b0;
    ctl(32'h0000_0009);
    ctl(32'h0000_0011);
    wait_st(ST_START);
    temp_ok <= 1'b0;
    wait_st(ST_FAULT);
    st(ST_FAULT, FLT_POLE_OT);
    ctl(32'h0000_0009);
    st(ST_FAULT, FLT_POLE_OT);
    temp_ok <= 1'b1;
    ctl(32'h0000_0009);
    st(ST_IDLE, FLT_NONE);
    open_leg <= 3'h2;
    ctl(32'h0000_0011);
    wait_st(ST_FAULT);
    st(ST_FAULT, FLT_OPEN_GATE);
    apb(1'b0, OFS_COUNT, 32'h0000_0000);
    chk(32'(rdv[3:0]), 32'h0000_0003);
    open_leg <= 3'h0;
    ctl(32'h0000_0009);
    apb(1'b1, OFS_CFG, 32'h0000_0003);
    ctl(32'h0000_0011);
    wait_st(ST_FAULT);
    st(ST_FAULT, FLT_STARTS);
    // reset in mid-test while a start-limit fault is latched
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(32'({fault_active, gate_enable, aux_out}), 32'h0000_0000);
    rst_n <= 1'b1;
    apb(1'b0, OFS_AUX, 32'h0000_0000);
    chk(rdv, 32'h0000_0231);
    st(ST_IDLE, FLT_NONE);
    report_and_stop();
  end
endmodule
`default_nettype wire
